// ==== include/pim_pkg.sv ====
// Purpose: Constants for the pin interrupt and pattern match engine
// Assumes: Byte-addressed Wishbone slave, 32-bit data
// Notes: Offsets are byte addresses
package pim_pkg;
  localparam int NCH = 8;
  localparam int NPINS = 64;
  localparam int SELW = 6;
  localparam logic [7:0] OFS_SEL_LO = 8'h00;
  localparam logic [7:0] OFS_SEL_HI = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_POLA = 8'h0c;
  localparam logic [7:0] OFS_POLB = 8'h10;
  localparam logic [7:0] OFS_ENGINE = 8'h14;
  localparam logic [7:0] OFS_TERM = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h20;
  localparam logic [7:0] OFS_LEVELS = 8'h24;
  localparam int TERM_BASE = 8;
  localparam int TERM_SEL_POS = 0;
  localparam int TERM_COND_POS = 3;
  localparam int TERM_END_POS = 6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int ENG_PM_POS = 0;
  localparam int ENG_EV_POS = 1;
  typedef enum logic [2:0] {
    PIM_C_ALWAYS = 3'h0, PIM_C_HIGH = 3'h1, PIM_C_LOW = 3'h2, PIM_C_RISE = 3'h3,
    PIM_C_FALL = 3'h4, PIM_C_EDGE = 3'h5, PIM_C_NEVER = 3'h6, PIM_C_HIGH2 = 3'h7
  } pim_cond_t;
  typedef enum logic [1:0] {
    PIM_ST_IDLE = 2'b01, PIM_ST_ACK = 2'b10
  } pim_bus_st_t;
endpackage

// ==== rtl/pim_sync.sv ====
// Purpose: Two-stage synchroniser for the pin bus
// Assumes: Single system clock
// Notes: First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pim_sync #(
  parameter int W = 64
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pim_sync
`default_nettype wire

// ==== rtl/pim_engine.sv ====
// Purpose: Pin interrupt and pattern match engine with Wishbone registers
// Assumes: 20 MHz sys_clk, async active-high rst
// Notes: Status is read-to-clear; set beats clear
// What this block does
// R1 - Software picks up to eight source pins, each edge or level sensitive.
// R2 - Each pin channel drives its own request line.
// R3 - Edge channels fire on rising, falling or both edges.
// R4 - Level channels request while the pin sits at its active level.
// R5 - Pin requests produce a wake-up indication in low-power states.
// R6 - Sources watch any pin whatever its routed function.
// R7 - Registers answer in one cycle with no wait states.
// R8 - Pattern mode evaluates a sum of terms over eight inputs.
// R9 - Each product term raises its own request when it becomes true.
// R10 - Any match can pulse the CPU event input and pin output.
// R11 - Pattern matches never produce wake-up.
// R12 - First two pin requests also go out as DMA triggers.
// R13 - Pin inputs are synchronised before edge or level detection.
`timescale 1ns/1ps
`default_nettype none
module pim_engine (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [pim_pkg::NPINS-1:0] pins,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [pim_pkg::NCH-1:0] chan_irq,
  output logic irq,
  output logic wake_req,
  output logic cpu_event_input,
  output logic event_pin,
  output logic pin_request_zero,
  output logic pin_request_one
);
  import pim_pkg::*;

  logic [NPINS-1:0] pins_s;
  logic [SELW-1:0] sel_q [NCH];
  logic [NCH-1:0] mode_q, pola_q, polb_q, status_q, mask_q, in_prev_q;
  logic [1:0] engine_q;
  logic [2:0] tsrc_q [NCH];
  pim_cond_t tcond_q [NCH];
  logic [NCH-1:0] tend_q;
  pim_bus_st_t bst_q;
  logic [NCH-1:0] term_prev_q;

  // Pin bus crosses into the clock domain first
  pim_sync #(.W(NPINS)) u_sync ( // [R13]
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(pins),
    .sync_out(pins_s)
  );

  function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                            input logic [3:0] s, input int b);
    merge_byte = s[b] ? d[8*b +: 8] : old;
  endfunction

  // Selection by index ignores the pad's routed function
  logic [NCH-1:0] in_now;
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      in_now[i] = pins_s[sel_q[i]]; // [R1] [R6]
    end
  end
  wire [NCH-1:0] rise = in_now & ~in_prev_q;
  wire [NCH-1:0] fall = ~in_now & in_prev_q;

  // Mode bit 1 = level; pola = rise/high, polb = fall/low
  wire [NCH-1:0] edge_hit = ~mode_q & ((rise & pola_q) | (fall & polb_q)); // [R3]
  wire [NCH-1:0] lvl_hit = mode_q & ((in_now & pola_q) | (~in_now & polb_q)); // [R4]
  wire pm_mode = engine_q[ENG_PM_POS];

  // Product terms: a term chains into the next until an end mark
  logic [NCH-1:0] lit, term_true;
  always_comb begin
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      case (tcond_q[i])
        PIM_C_ALWAYS: lit[i] = 1'b1;
        PIM_C_HIGH: lit[i] = in_now[tsrc_q[i]];
        PIM_C_LOW: lit[i] = ~in_now[tsrc_q[i]];
        PIM_C_RISE: lit[i] = rise[tsrc_q[i]];
        PIM_C_FALL: lit[i] = fall[tsrc_q[i]];
        PIM_C_EDGE: lit[i] = rise[tsrc_q[i]] | fall[tsrc_q[i]];
        PIM_C_HIGH2: lit[i] = in_now[tsrc_q[i]];
        default: lit[i] = 1'b0;
      endcase
    end
    for (int i = 0; i < NCH; i++) begin
      acc = acc & lit[i];
      term_true[i] = tend_q[i] & acc; // [R8]
      if (tend_q[i]) begin
        acc = 1'b1;
      end
    end
  end
  wire [NCH-1:0] term_rise = term_true & ~term_prev_q; // [R9]
  wire [NCH-1:0] chan_hit = pm_mode ? (term_true & tend_q) : (edge_hit | lvl_hit); // [R2]
  wire [NCH-1:0] chan_evt = pm_mode ? term_rise : (edge_hit | (lvl_hit & ~status_q));

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & (bst_q == PIM_ST_IDLE);
  wire wr = bus_req & wb_we_i;
  wire rd = bus_req & ~wb_we_i;
  wire hit_sel_lo = (wb_adr_i == OFS_SEL_LO);
  wire hit_sel_hi = (wb_adr_i == OFS_SEL_HI);
  wire hit_mode = (wb_adr_i == OFS_MODE);
  wire hit_pola = (wb_adr_i == OFS_POLA);
  wire hit_polb = (wb_adr_i == OFS_POLB);
  wire hit_eng = (wb_adr_i == OFS_ENGINE);
  wire hit_term = (wb_adr_i >= OFS_TERM) && (wb_adr_i < OFS_TERM + 8'h04) ;
  wire hit_stat = (wb_adr_i == OFS_STATUS);
  wire hit_mask = (wb_adr_i == OFS_MASK);
  wire hit_lvl = (wb_adr_i == OFS_LEVELS);
  wire [NCH-1:0] stat_clr = (rd && hit_stat) ? status_q : '0;

  logic [31:0] rdata;
  always_comb begin
    rdata = RST_WORD;
    if (hit_sel_lo) begin
      for (int i = 0; i < 4; i++) rdata[8*i +: 8] = {2'b00, sel_q[i]};
    end else if (hit_sel_hi) begin
      for (int i = 0; i < 4; i++) rdata[8*i +: 8] = {2'b00, sel_q[i+4]};
    end else if (hit_mode) begin
      rdata[7:0] = mode_q;
    end else if (hit_pola) begin
      rdata[7:0] = pola_q;
    end else if (hit_polb) begin
      rdata[7:0] = polb_q;
    end else if (hit_eng) begin
      rdata[1:0] = engine_q;
    end else if (hit_term) begin
      for (int i = 0; i < NCH; i++) rdata[4*i +: 4] = {tend_q[i], tsrc_q[i]};
    end else if (hit_stat) begin
      rdata[7:0] = status_q;
    end else if (hit_mask) begin
      rdata[7:0] = mask_q;
    end else if (hit_lvl) begin
      rdata[15:0] = {term_true, in_now};
    end
  end

  // Term conditions sit in a second word after the term layout word
  wire hit_tcond = (wb_adr_i == OFS_TERM + 8'h04);
  logic [31:0] tcond_rd;
  always_comb begin
    for (int i = 0; i < NCH; i++) tcond_rd[4*i +: 4] = {1'b0, tcond_q[i]};
  end

  // One-cycle ack, then one idle cycle so ack drops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bst_q <= PIM_ST_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      case (bst_q)
        PIM_ST_IDLE: begin
          wb_ack_o <= bus_req; // [R7]
          wb_dat_o <= hit_tcond ? tcond_rd : rdata;
          bst_q <= bus_req ? PIM_ST_ACK : PIM_ST_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          bst_q <= PIM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        sel_q[i] <= '0;
        tsrc_q[i] <= '0;
        tcond_q[i] <= PIM_C_NEVER;
      end
      mode_q <= RST_BYTE;
      pola_q <= RST_BYTE;
      polb_q <= RST_BYTE;
      mask_q <= RST_BYTE;
      tend_q <= RST_BYTE;
      engine_q <= '0;
    end else if (wr) begin
      if (hit_sel_lo || hit_sel_hi) begin
        for (int i = 0; i < 4; i++) begin
          if (wb_sel_i[i]) sel_q[hit_sel_hi ? i+4 : i] <= wb_dat_i[8*i +: SELW]; // [R1]
        end
      end else if (hit_mode) begin
        mode_q <= merge_byte(mode_q, wb_dat_i, wb_sel_i, 0);
      end else if (hit_pola) begin
        pola_q <= merge_byte(pola_q, wb_dat_i, wb_sel_i, 0);
      end else if (hit_polb) begin
        polb_q <= merge_byte(polb_q, wb_dat_i, wb_sel_i, 0);
      end else if (hit_eng) begin
        if (wb_sel_i[0]) engine_q <= wb_dat_i[1:0];
      end else if (hit_term) begin
        for (int i = 0; i < NCH; i++) begin
          if (wb_sel_i[i/2]) begin
            tsrc_q[i] <= wb_dat_i[4*i +: 3];
            tend_q[i] <= wb_dat_i[4*i+3];
          end
        end
      end else if (hit_tcond) begin
        for (int i = 0; i < NCH; i++) begin
          if (wb_sel_i[i/2]) tcond_q[i] <= pim_cond_t'(wb_dat_i[4*i +: 3]);
        end
      end else if (hit_mask) begin
        mask_q <= merge_byte(mask_q, wb_dat_i, wb_sel_i, 0);
      end
    end
  end

  wire [NCH-1:0] status_d = (status_q & ~stat_clr) | chan_evt; // Set wins over clear
  wire any_match = pm_mode & (|term_rise);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_prev_q <= RST_BYTE;
      term_prev_q <= RST_BYTE;
      status_q <= RST_BYTE;
      chan_irq <= RST_BYTE;
      irq <= 1'b0;
      wake_req <= 1'b0;
      cpu_event_input <= 1'b0;
      event_pin <= 1'b0;
      pin_request_zero <= 1'b0;
      pin_request_one <= 1'b0;
    end else begin
      in_prev_q <= in_now;
      term_prev_q <= term_true;
      status_q <= status_d;
      chan_irq <= chan_hit; // [R2] [R9]
      irq <= |(status_d & mask_q);
      wake_req <= ~pm_mode & (|(edge_hit | lvl_hit)); // [R5] [R11]
      cpu_event_input <= any_match & engine_q[ENG_EV_POS]; // [R10]
      event_pin <= any_match & engine_q[ENG_EV_POS]; // [R10]
      pin_request_zero <= ~pm_mode & chan_hit[0]; // [R12]
      pin_request_one <= ~pm_mode & chan_hit[1]; // [R12]
    end
  end

  AST_ACK_ONE_CYCLE: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given in one cycle");
  AST_EVENT_ONLY_PM: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    cpu_event_input |-> $past(pm_mode) && $past(engine_q[ENG_EV_POS]))
    else $error("event pulse outside pattern mode");
  AST_EVENT_PULSE: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    cpu_event_input |-> event_pin)
    else $error("event pin does not follow event");
  AST_NO_PM_WAKE: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    $past(pm_mode) |-> !wake_req)
    else $error("wake from pattern mode");
  AST_WAKE_FROM_PIN: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (!pm_mode && |(edge_hit | lvl_hit)) |=> wake_req)
    else $error("pin request did not wake");
  AST_DMA_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
    pin_request_zero |-> chan_irq[0])
    else $error("dma trigger zero without channel");
  AST_CHAN_RISE: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    (!pm_mode && !mode_q[0] && pola_q[0] && rise[0]) |=> chan_irq[0])
    else $error("rising edge missed");
  AST_LEVEL_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    (!pm_mode && mode_q[2] && pola_q[2] && in_now[2]) |=> chan_irq[2])
    else $error("level request missing");
  AST_SYNC_DELAY: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    !rst |-> ##2 (pins_s == $past(pins, 2)))
    else $error("synchroniser depth wrong");
  AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    irq |-> |(status_q & mask_q))
    else $error("irq without unmasked status");
  COV_EDGE: cover property (@(posedge sys_clk) disable iff (rst) pin_request_zero);
  COV_MATCH: cover property (@(posedge sys_clk) disable iff (rst) cpu_event_input);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) irq ##1 !irq);
endmodule // pim_engine
`default_nettype wire

// ==== test/pim_cpu_model.sv ====
// Purpose: Interrupt controller, CPU event input and DMA trigger sink
// Assumes: Single sys_clk, async active-high rst
// Notes: Counts rising edges per line; level lines count once per assertion
`timescale 1ns/1ps
`default_nettype none
module pim_cpu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] chan_irq,
  input wire logic cpu_event_input,
  input wire logic event_pin,
  input wire logic wake_req,
  input wire logic pin_request_zero,
  input wire logic pin_request_one,
  output logic [7:0][7:0] rise_cnt,
  output logic [7:0] ev_cnt,
  output logic [7:0] pin_ev_cnt,
  output logic [7:0] wake_cnt,
  output logic [7:0] dma0_cnt,
  output logic [7:0] dma1_cnt
);
  logic [12:0] prev_q;
  wire logic [12:0] now_w;
  wire logic [12:0] rise_w;
  assign now_w = {chan_irq, cpu_event_input, event_pin, wake_req, pin_request_zero, pin_request_one};
  assign rise_w = now_w & ~prev_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
      rise_cnt <= '0;
      ev_cnt <= '0;
      pin_ev_cnt <= '0;
      wake_cnt <= '0;
      dma0_cnt <= '0;
      dma1_cnt <= '0;
    end else begin
      prev_q <= now_w;
      for (int i = 0; i < 8; i++) begin
        if (rise_w[i+5]) rise_cnt[i] <= rise_cnt[i] + 8'h01;
      end
      if (rise_w[4]) ev_cnt <= ev_cnt + 8'h01;
      if (rise_w[3]) pin_ev_cnt <= pin_ev_cnt + 8'h01;
      if (rise_w[2]) wake_cnt <= wake_cnt + 8'h01;
      if (rise_w[1]) dma0_cnt <= dma0_cnt + 8'h01;
      if (rise_w[0]) dma1_cnt <= dma1_cnt + 8'h01;
    end
  end
endmodule // pim_cpu_model
`default_nettype wire

// ==== test/pin_interrupt_pattern_match_tb_top.sv ====
// Purpose: Self-checking bench for the pin interrupt and pattern match engine
// Assumes: 20 MHz sys_clk, Wishbone classic master tasks
// Notes: Pin events take three edges to show; waits of six cycles cover that
`timescale 1ns/1ps
`default_nettype none
module pin_interrupt_pattern_match_tb_top;
  import pim_pkg::*;
  logic sys_clk, rst, cyc, stb, we;
  logic [NPINS-1:0] pins;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic ack, irq, wake, cev, evp, pr0, pr1;
  logic [NCH-1:0] chan_irq;
  logic [7:0][7:0] rise_cnt;
  logic [7:0] ev_cnt, pin_ev_cnt, wake_cnt, dma0_cnt, dma1_cnt, w0, e0, r1, r2;
  int errors, total_checks, cycles;
  pim_engine pim_engine_inst (.sys_clk(sys_clk), .rst(rst), .pins(pins), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .chan_irq(chan_irq), .irq(irq), .wake_req(wake), .cpu_event_input(cev), .event_pin(evp),
    .pin_request_zero(pr0), .pin_request_one(pr1));
  pim_cpu_model pim_cpu_model_inst (.sys_clk(sys_clk), .rst(rst), .chan_irq(chan_irq), .cpu_event_input(cev),
    .event_pin(evp), .wake_req(wake), .pin_request_zero(pr0), .pin_request_one(pr1), .rise_cnt(rise_cnt),
    .ev_cnt(ev_cnt), .pin_ev_cnt(pin_ev_cnt), .wake_cnt(wake_cnt), .dma0_cnt(dma0_cnt), .dma1_cnt(dma1_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // One bus cycle; ack must be sampled on the second edge, no wait states
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    chk(n, 2, "ack latency");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0;
    pins = '0; errors = 0; total_checks = 0; cycles = 0;
    tick(10);
    rst <= 1'b0;
    wb(1'b0, OFS_MASK, 32'h0, q); chk(q, RST_WORD, "mask reset");
    wb(1'b0, 8'hfc, 32'h0, q); chk(q, 32'h0, "unmapped read");
    // ch0 pin5 rise, ch1 pin40 both, ch2 pin12 high level, ch3 pin63 low level, ch4 pin5 fall
    wb(1'b1, OFS_SEL_LO, 32'h3f0c2805, q);
    wb(1'b1, OFS_SEL_HI, 32'h00000005, q);
    wb(1'b1, OFS_MODE, 32'h0000000c, q);
    wb(1'b1, OFS_POLA, 32'h00000007, q);
    wb(1'b1, OFS_POLB, 32'h0000001a, q);
    wb(1'b0, OFS_POLA, 32'h0, q); chk(q, 32'h07, "pola readback");
    tick(6);
    chk(chan_irq[3], 1'b1, "low-active level");
    chk(chan_irq[2], 1'b0, "high-active idle");
    pins[63] <= 1'b1; pins[12] <= 1'b1; tick(6);
    chk(chan_irq[3], 1'b0, "low-active released");
    chk(chan_irq[2], 1'b1, "high-active level");
    pins[12] <= 1'b0; tick(6);
    w0 = wake_cnt;
    pins[5] <= 1'b1; pins[40] <= 1'b1; tick(6);
    chk(rise_cnt[0], 8'h01, "ch0 rise");
    chk(rise_cnt[1], 8'h01, "ch1 rise");
    chk(rise_cnt[4], 8'h00, "ch4 ignores rise");
    chk(dma0_cnt, 8'h01, "dma trigger 0");
    chk(dma1_cnt, 8'h01, "dma trigger 1");
    chk(wake_cnt, w0 + 8'h01, "wake on pin hit");
    pins[5] <= 1'b0; pins[40] <= 1'b0; tick(6);
    chk(rise_cnt[0], 8'h01, "ch0 no fall");
    chk(rise_cnt[1], 8'h02, "ch1 fall");
    chk(rise_cnt[4], 8'h01, "ch4 fall");
    wb(1'b1, OFS_MASK, 32'h1, q); tick(2);
    chk(irq, 1'b1, "irq unmasked status");
    // Channels 0 to 4 have each latched their sticky bit; channels 5 to 7 never fired
    wb(1'b0, OFS_STATUS, 32'h0, q); chk(q, 32'h0000001f, "sticky status");
    tick(2);
    chk(irq, 1'b0, "irq after read clear");
    wb(1'b1, OFS_MASK, 32'h0, q);
    pins[5] <= 1'b1; tick(6);
    chk(irq, 1'b0, "irq masked");
    wb(1'b1, OFS_MASK, 32'h1, q); tick(2);
    chk(irq, 1'b1, "irq on unmask");
    pins[5] <= 1'b0; tick(6);
    // Conditions before the term word so no ALWAYS term fires early
    wb(1'b1, OFS_TERM + 8'h04, 32'h00000001, q);
    wb(1'b1, OFS_TERM, 32'h00000008, q);
    wb(1'b1, OFS_ENGINE, 32'h00000003, q);
    tick(6);
    w0 = wake_cnt; e0 = ev_cnt;
    pins[5] <= 1'b1; tick(6);
    chk(chan_irq[0], 1'b1, "term true");
    chk(ev_cnt, e0 + 8'h01, "cpu event pulse");
    chk(pin_ev_cnt, e0 + 8'h01, "event pin copy");
    chk(wake_cnt, w0, "no wake in pattern mode");
    chk(pr0, 1'b0, "no dma trigger in pattern mode");
    // Two chained terms: ch0 high and ch1 rising, then ch1 falling alone
    wb(1'b1, OFS_TERM + 8'h04, 32'h66666431, q);
    wb(1'b1, OFS_TERM, 32'h00000990, q);
    wb(1'b0, OFS_TERM + 8'h04, 32'h0, q); chk(q, 32'h66666431, "term condition readback");
    wb(1'b0, OFS_TERM, 32'h0, q); chk(q, 32'h00000990, "term layout readback");
    tick(6);
    e0 = ev_cnt; r1 = rise_cnt[1]; r2 = rise_cnt[2];
    pins[40] <= 1'b1; tick(6);
    chk(rise_cnt[1], r1 + 8'h01, "high and rise term");
    chk(ev_cnt, e0 + 8'h01, "event on first term");
    pins[40] <= 1'b0; tick(6);
    chk(rise_cnt[2], r2 + 8'h01, "fall term");
    chk(rise_cnt[1], r1 + 8'h01, "first term idle on fall");
    pins[5] <= 1'b0; tick(6);
    pins[40] <= 1'b1; tick(6);
    chk(rise_cnt[1], r1 + 8'h01, "rise without high level");
    chk(ev_cnt, e0 + 8'h02, "event count");
    // Mid-run reset with pins still high must not leave stale requests
    rst <= 1'b1; tick(2);
    rst <= 1'b0;
    wb(1'b0, OFS_ENGINE, 32'h0, q); chk(q, RST_WORD, "engine after reset");
    chk(chan_irq, 8'h00, "channels after reset");
    chk(irq, 1'b0, "irq after reset");
    summarize();
  end
endmodule // pin_interrupt_pattern_match_tb_top
`default_nettype wire
